/* File: esq_event_step_sequencer.sv */
// esq_event_step_sequencer: sixteen-step event/time sequencer with AXI4-Lite registers.
// assumes start, jog, reset and events come from logic outside this clock domain.
//
// How it works
// - entering run mode non-retentive loads the current step from the preset step first
// - reset beats start; holds preset step, no timing, no events
// - start low freezes timer and step count; counting resumes from there
// - last step done sets completion, holds step, ignores start and jog
// - reset during completion clears the flag and enters the preset step
// - each jog rising edge advances one step when reset is low
// - jog clears the step count; runs at once if start is high
// - jog in the last step moves to completed and sets the flag
// - sixteen steps, each with count, event select and output pattern
// - timer counts only while start and the step's event are true
// - count reaching the step's counts value moves to the next step
// - four status words: step count, timer, preset step, current step
// - preset step writable any time; other three read only
// - only the first word carries a flag bit, meaning completion
// - outputs follow the current step pattern in run mode always
// - program to run, non-retentive, shows the preset step pattern two cycles after run is set
// - each step selects one event input, or none with the unassigned code
// - each pattern is sixteen bits, one per output
// - timer value advances in hundredths of a second
// - non-retentive restarts at preset and zero; retentive keeps state
`timescale 1ns/1ps

module esq_event_step_sequencer #(
    parameter int HUND_CYCLES = esq_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    // axi4-lite slave
    input wire logic [esq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [esq_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // control from the surrounding logic
    input wire logic seq_start,
    input wire logic seq_jog,
    input wire logic seq_reset,
    input wire logic [esq_pkg::STEPS-1:0] event_in,
    // results
    output logic [esq_pkg::PAT_W-1:0] step_out,
    output logic completion_flag,
    output logic [esq_pkg::STEP_W-1:0] current_step
);

    typedef struct packed {
        // bus side
        logic aw_held;
        logic [esq_pkg::ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // configuration
        logic run;
        logic retain;
        logic [esq_pkg::CNT_W-1:0] timebase;
        logic [esq_pkg::STEP_W-1:0] last;
        logic [esq_pkg::STEP_W-1:0] preset;
        logic [esq_pkg::STEPS-1:0][esq_pkg::CNT_W-1:0] counts;
        logic [esq_pkg::STEPS-1:0][esq_pkg::SEL_W-1:0] evsel;
        logic [esq_pkg::STEPS-1:0][esq_pkg::PAT_W-1:0] pattern;
        // sequencer
        esq_pkg::esq_mode_t mode;
        logic [esq_pkg::STEP_W-1:0] cur;
        logic [esq_pkg::CNT_W-1:0] step_cnt;
        logic [esq_pkg::CNT_W-1:0] tval;
        logic [esq_pkg::HUND_W-1:0] hund;
        logic done;
        logic [esq_pkg::PAT_W-1:0] pat_out;
        // synchronisers
        logic start_m;
        logic start_s;
        logic jog_m;
        logic jog_s;
        logic jog_d;
        logic rst_m;
        logic rst_s;
        logic [esq_pkg::STEPS-1:0] ev_m;
        logic [esq_pkg::STEPS-1:0] ev_s;
    } esq_regs_t;

    // constant state after power-up: non-retentive start
    function automatic esq_regs_t esq_reset_value();
        esq_regs_t r;
        r = '0;
        r.timebase = esq_pkg::TIMEBASE_RST;
        r.last = esq_pkg::LAST_RST;
        r.preset = esq_pkg::PRESET_RST;
        r.cur = esq_pkg::PRESET_RST;
        r.mode = esq_pkg::ESQ_PROG;
        return r;
    endfunction : esq_reset_value

    localparam esq_regs_t RST_VALUE = esq_reset_value();

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] esq_merge(
        input logic [31:0] old,
        input logic [31:0] d,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : esq_merge

    // step numbers live in 1..16; out-of-range writes are pulled in
    function automatic logic [4:0] esq_clamp(input logic [4:0] v);
        logic [4:0] r;
        r = v;
        if (v == 5'h00) begin
            r = 5'h01;
        end else if (v > 5'h10) begin
            r = 5'h10;
        end
        return r;
    endfunction : esq_clamp

    // a step watches one event; the unassigned code counts on time alone
    function automatic logic esq_event_ok(
        input logic [4:0] sel,
        input logic [15:0] ev
    );
        logic r;
        r = 1'b1;
        if (sel != esq_pkg::UNASSIGNED_CODE && sel <= 5'h10) begin
            r = ev[4'(sel - 5'h01)];
        end
        return r;
    endfunction : esq_event_ok

    localparam logic [esq_pkg::HUND_W-1:0] HUND_LAST = esq_pkg::HUND_W'(HUND_CYCLES - 1);

    esq_regs_t s;
    esq_regs_t next_s;

    // handshakes straight from held state
    assign s_axi_awready = !s.aw_held && !s.bvalid;
    assign s_axi_wready = !s.w_held && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign step_out = s.pat_out;
    assign completion_flag = s.done;
    assign current_step = s.cur;

    // next state: bus slave, then the sequencer proper
    always_comb begin
        logic [31:0] rd;
        logic [31:0] wd;
        logic [1:0] rsp;
        logic [3:0] ix;
        logic [3:0] wix;
        logic [13:0] tb;
        logic adv;
        logic load;
        logic jog_edge;
        rd = 32'h0000_0000;
        wd = 32'h0000_0000;
        rsp = esq_pkg::RESP_OKAY;
        ix = 4'(s.cur - 5'h01);
        wix = s.aw_addr[5:2];
        tb = (s.timebase == 14'h0000) ? 14'h0001 : s.timebase;
        adv = 1'b0;
        load = 1'b0;
        jog_edge = s.jog_s && !s.jog_d;
        next_s = s;

        // write address and data are caught in either order
        if (!s.aw_held && !s.bvalid && s_axi_awvalid) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (!s.w_held && !s.bvalid && s_axi_wvalid) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // both halves held: perform the write, answer next cycle
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            unique case (s.aw_addr[7:6])
                esq_pkg::TBL_REGS: begin
                    next_s.bresp = esq_pkg::RESP_OKAY;
                    unique case ({s.aw_addr[7:2], 2'b00})
                        esq_pkg::REG_CTRL: begin
                            wd = esq_merge({30'h0, s.retain, s.run}, s.w_data, s.w_strb);
                            next_s.run = wd[esq_pkg::CTRL_RUN];
                            next_s.retain = wd[esq_pkg::CTRL_RETAIN];
                        end
                        esq_pkg::REG_TIMEBASE: begin
                            wd = esq_merge({18'h0, s.timebase}, s.w_data, s.w_strb);
                            next_s.timebase = wd[13:0];
                        end
                        esq_pkg::REG_LAST: begin
                            wd = esq_merge({27'h0, s.last}, s.w_data, s.w_strb);
                            next_s.last = esq_clamp(wd[4:0]);
                        end
                        esq_pkg::REG_PRESET: begin
                            // takes effect at the next reset while running, or at non-retentive run entry
                            wd = esq_merge({27'h0, s.preset}, s.w_data, s.w_strb);
                            next_s.preset = esq_clamp(wd[4:0]);
                        end
                        // the three read-only status words ignore writes but answer okay
                        esq_pkg::REG_STEP_COUNT, esq_pkg::REG_TIMER,
                        esq_pkg::REG_CURRENT: begin
                            wd = 32'h0000_0000;
                        end
                        default: begin
                            next_s.bresp = esq_pkg::RESP_SLVERR;
                        end
                    endcase
                end
                esq_pkg::TBL_COUNTS: begin
                    wd = esq_merge({18'h0, s.counts[wix]}, s.w_data, s.w_strb);
                    next_s.counts[wix] = wd[13:0];
                    next_s.bresp = esq_pkg::RESP_OKAY;
                end
                esq_pkg::TBL_EVENT: begin
                    wd = esq_merge({27'h0, s.evsel[wix]}, s.w_data, s.w_strb);
                    next_s.evsel[wix] = wd[4:0];
                    next_s.bresp = esq_pkg::RESP_OKAY;
                end
                esq_pkg::TBL_PATTERN: begin
                    wd = esq_merge({16'h0, s.pattern[wix]}, s.w_data, s.w_strb);
                    next_s.pattern[wix] = wd[15:0];
                    next_s.bresp = esq_pkg::RESP_OKAY;
                end
            endcase
        end

        // read: one outstanding, data registered with the valid
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (!s.rvalid && s_axi_arvalid) begin
            unique case (s_axi_araddr[7:6])
                esq_pkg::TBL_REGS: begin
                    unique case ({s_axi_araddr[7:2], 2'b00})
                        esq_pkg::REG_CTRL: rd = {30'h0, s.retain, s.run};
                        esq_pkg::REG_TIMEBASE: rd = {18'h0, s.timebase};
                        esq_pkg::REG_LAST: rd = {27'h0, s.last};
                        // only the first status word carries a flag
                        esq_pkg::REG_STEP_COUNT: begin
                            rd = {18'h0, s.step_cnt};
                            rd[esq_pkg::DONE_BIT] = s.done;
                        end
                        esq_pkg::REG_TIMER: rd = {18'h0, s.tval};
                        esq_pkg::REG_PRESET: rd = {27'h0, s.preset};
                        esq_pkg::REG_CURRENT: rd = {27'h0, s.cur};
                        default: rsp = esq_pkg::RESP_SLVERR;
                    endcase
                end
                esq_pkg::TBL_COUNTS: rd = {18'h0, s.counts[s_axi_araddr[5:2]]};
                esq_pkg::TBL_EVENT: rd = {27'h0, s.evsel[s_axi_araddr[5:2]]};
                esq_pkg::TBL_PATTERN: rd = {16'h0, s.pattern[s_axi_araddr[5:2]]};
            endcase
            next_s.rvalid = 1'b1;
            next_s.rdata = rd;
            next_s.rresp = rsp;
        end

        // two flops on every outside input
        next_s.start_m = seq_start;
        next_s.start_s = s.start_m;
        next_s.jog_m = seq_jog;
        next_s.jog_s = s.jog_m;
        next_s.jog_d = s.jog_s;
        next_s.rst_m = seq_reset;
        next_s.rst_s = s.rst_m;
        next_s.ev_m = event_in;
        next_s.ev_s = s.ev_m;

        // step control
        unique case (s.mode)
            esq_pkg::ESQ_PROG: begin
                if (s.run) begin
                    // retentive runs resume where they stopped
                    next_s.mode = (s.retain && s.done) ? esq_pkg::ESQ_DONE : esq_pkg::ESQ_RUN;
                    load = !s.retain;
                end
            end
            esq_pkg::ESQ_RUN: begin
                if (!s.run) begin
                    next_s.mode = esq_pkg::ESQ_PROG;
                end else if (s.rst_s) begin
                    load = 1'b1;
                end else if (jog_edge) begin
                    adv = 1'b1;
                end else if (s.start_s && esq_event_ok(s.evsel[ix], s.ev_s)) begin
                    // start low freezes the timer and step count; reset and jog still act
                    if (s.hund == HUND_LAST) begin
                        next_s.hund = '0;
                        if (s.tval + 14'h0001 >= tb) begin
                            next_s.tval = '0;
                            if (s.step_cnt + 14'h0001 >= s.counts[ix]) begin
                                adv = 1'b1;
                            end else begin
                                next_s.step_cnt = s.step_cnt + 14'h0001;
                            end
                        end else begin
                            next_s.tval = s.tval + 14'h0001;
                        end
                    end else begin
                        next_s.hund = s.hund + 20'h00001;
                    end
                end
            end
            esq_pkg::ESQ_DONE: begin
                // start and jog have no effect here
                if (!s.run) begin
                    next_s.mode = esq_pkg::ESQ_PROG;
                end else if (s.rst_s) begin
                    next_s.mode = esq_pkg::ESQ_RUN;
                    load = 1'b1;
                end
            end
            default: begin
                next_s.mode = esq_pkg::ESQ_PROG;
            end
        endcase

        // preset entry clears counts and completion
        if (load) begin
            next_s.cur = s.preset;
            next_s.step_cnt = '0;
            next_s.tval = '0;
            next_s.hund = '0;
            next_s.done = 1'b0;
        end

        // step advance; a preset past the last step also completes
        if (adv) begin
            next_s.step_cnt = '0;
            next_s.tval = '0;
            next_s.hund = '0;
            if (s.cur >= s.last) begin
                next_s.mode = esq_pkg::ESQ_DONE;
                next_s.done = 1'b1;
            end else begin
                next_s.cur = s.cur + 5'h01;
            end
        end

        // outputs follow the step a cycle later, blind to start and reset
        if (s.mode != esq_pkg::ESQ_PROG) begin
            next_s.pat_out = s.pattern[ix];
        end else begin
            next_s.pat_out = '0;
        end
    end

    // single state register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= RST_VALUE;
        end else begin
            s <= next_s;
        end
    end

endmodule : esq_event_step_sequencer

/* File: esq_pkg.sv */
// esq_pkg: constants, register map and state record of the event step sequencer.
// assumes one 40 MHz clock and an AXI4-Lite bus with byte addresses of 8 bits.
package esq_pkg;

    // sizes of the step table
    localparam int STEPS = 16;
    localparam int CNT_W = 14;
    localparam int STEP_W = 5;
    localparam int SEL_W = 5;
    localparam int PAT_W = 16;
    localparam int ADDR_W = 8;
    localparam int HUND_W = 20;

    // timebase: one timer unit is a hundredth of a second
    localparam int TICK_NS = 10000000;
    localparam int CLK_NS = 25;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TIMEBASE = 8'h04;
    localparam logic [7:0] REG_LAST = 8'h08;
    localparam logic [7:0] REG_STEP_COUNT = 8'h10;
    localparam logic [7:0] REG_TIMER = 8'h14;
    localparam logic [7:0] REG_PRESET = 8'h18;
    localparam logic [7:0] REG_CURRENT = 8'h1C;
    localparam logic [1:0] TBL_REGS = 2'h0;
    localparam logic [1:0] TBL_COUNTS = 2'h1;
    localparam logic [1:0] TBL_EVENT = 2'h2;
    localparam logic [1:0] TBL_PATTERN = 2'h3;

    // field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RETAIN = 1;
    localparam int DONE_BIT = 16;

    // values after reset
    localparam logic [4:0] PRESET_RST = 5'h01;
    localparam logic [4:0] LAST_RST = 5'h10;
    localparam logic [13:0] TIMEBASE_RST = 14'h0001;
    localparam logic [4:0] UNASSIGNED_CODE = 5'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ESQ_PROG = 2'b00,
        ESQ_RUN = 2'b01,
        ESQ_DONE = 2'b11
    } esq_mode_t;

endpackage : esq_pkg

/* File: esq_event_step_sequencer_checker.sv */
// esq_event_step_sequencer_checker: port properties of the step sequencer.
// assumes one clock; start, jog and reset pass two sync flops inside the design.
`timescale 1ns/1ps

module esq_event_step_sequencer_checker #(
    parameter int HUND_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic seq_start,
    input wire logic seq_jog,
    input wire logic seq_reset,
    input wire logic [esq_pkg::PAT_W-1:0] step_out,
    input wire logic completion_flag,
    input wire logic [esq_pkg::STEP_W-1:0] current_step
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // jog rising edge while the sequence is live
    sequence jog_edge_s;
        !seq_jog ##1 (seq_jog && !seq_reset && !completion_flag);
    endsequence
    // controls idle long enough to clear the sync flops
    sequence quiet_s;
        (!seq_start && !seq_jog && !seq_reset) [*5];
    endsequence

    step_range_a: assert property (
        current_step >= 5'h01 && current_step <= 5'h10)
        else $error("current step out of range");
    jog_advance_a: assert property (
        jog_edge_s |-> ##[1:5] ($changed(current_step) || $rose(completion_flag)))
        else $error("jog edge did not advance");
    step_by_one_a: assert property (
        $changed(current_step) && !seq_reset && !$past(seq_reset)
        && !$past(seq_reset, 2) && !$past(seq_reset, 3) && !$past(seq_reset, 4)
        |-> current_step == $past(current_step) + 5'h01)
        else $error("step moved by other than one");
    out_follows_a: assert property (
        $changed(current_step) |-> $stable(step_out) ##1 $changed(step_out))
        else $error("pattern did not follow step one cycle later");
    done_keeps_a: assert property (
        $rose(completion_flag) |-> $stable(current_step) && current_step == 5'h10)
        else $error("completion left the last step");
    done_stays_a: assert property (
        completion_flag && !seq_reset && !$past(seq_reset)
        |=> completion_flag && $stable(current_step))
        else $error("completed sequence moved without reset");
    reset_holds_a: assert property (
        seq_reset [*6] |-> $stable(current_step))
        else $error("step moved while reset held");
    reset_clears_a: assert property (
        seq_reset [*6] |-> !completion_flag)
        else $error("completion stayed under reset");
    freeze_a: assert property (
        quiet_s |-> $stable(current_step) && $stable(completion_flag))
        else $error("sequence moved with start low");
endmodule : esq_event_step_sequencer_checker

bind esq_event_step_sequencer esq_event_step_sequencer_checker #(
    .HUND_CYCLES(HUND_CYCLES)
) u_chk (
    .ref_clk, .reset_n, .seq_start, .seq_jog, .seq_reset, .step_out, .completion_flag,
    .current_step
);

/* File: esq_ladder_model.sv */
// esq_ladder_model: control rungs in front of the sequencer's start, jog and reset.
// assumes level requests from the bench; outputs change just after ref_clk rises.
`timescale 1ns/1ps

module esq_ladder_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start_req,
    input wire logic jog_req,
    input wire logic reset_req,
    input wire logic auto_restart,
    input wire logic completion_flag,
    output logic seq_start,
    output logic seq_jog,
    output logic seq_reset
);
    // registered rungs; completion ORed into reset makes a self-restarting sequence
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            seq_start <= 1'b0;
            seq_jog <= 1'b0;
            seq_reset <= 1'b0;
        end else begin
            seq_start <= start_req;
            seq_jog <= jog_req;
            seq_reset <= reset_req | (auto_restart & completion_flag);
        end
    end
endmodule : esq_ladder_model

/* File: esq_event_step_sequencer_tb.sv */
// esq_event_step_sequencer_tb: directed tests of the step sequencer.
// assumes design, package, checker bind and ladder model compiled first.
`timescale 1ns/1ps

module esq_event_step_sequencer_tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata, rd, a, b;
    logic [15:0] event_in = 16'h0000;
    logic start_req = 1'b0, jog_req = 1'b0, reset_req = 1'b0, auto_restart = 1'b0;
    logic seq_start, seq_jog, seq_reset, completion_flag;
    logic [15:0] step_out;
    logic [4:0] current_step;
    int err_total = 0;
    int checks = 0;

    // 40 MHz
    always #12.5 ref_clk = ~ref_clk;

    // hundredth shortened to 4 clocks so a full sequence fits a short run
    esq_event_step_sequencer #(.HUND_CYCLES(4)) dut (
        .ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seq_start, .seq_jog, .seq_reset,
        .event_in, .step_out, .completion_flag, .current_step);

    esq_ladder_model ladder (
        .ref_clk, .reset_n, .start_req, .jog_req, .reset_req, .auto_restart,
        .completion_flag, .seq_start, .seq_jog, .seq_reset);

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rr = s_axi_bresp;
    endtask : wr

    task automatic rdreg(input logic [7:0] ad);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask : rdreg

    task automatic wait_step(input logic [4:0] s, input int n);
        for (int i = 0; i < n && current_step !== s; i++) @(posedge ref_clk);
        chk("current_step", 32'(s), 32'(current_step));
    endtask : wait_step

    // jog pulse with a low gap long enough for the edge detector
    task automatic jog();
        jog_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        jog_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : jog

    function automatic logic [15:0] pat(input int k);
        if (k == 1) return 16'h0081;
        if (k == 5) return 16'h0000;
        if (k == 16) return 16'hFFFF;
        return 16'h5A00 | 16'(k);
    endfunction : pat

    task automatic t_regs();
        wait_step(5'h01, 1);
        chk("completion", 32'h0, 32'(completion_flag));
        rdreg(esq_pkg::REG_PRESET);
        chk("preset", 32'h1, rd);
        rdreg(esq_pkg::REG_STEP_COUNT);
        chk("step count", 32'h0, rd);
        rdreg(8'h0C);
        chk("unmapped resp", 32'(esq_pkg::RESP_SLVERR), 32'(rr));
        wr(esq_pkg::REG_CURRENT, 32'h7);
        chk("ro write resp", 32'(esq_pkg::RESP_OKAY), 32'(rr));
        rdreg(esq_pkg::REG_CURRENT);
        chk("current ro", 32'h1, rd);
        for (int i = 0; i < 16; i++) begin
            wr(8'(8'h40 + 4 * i), (i == 2) ? 32'h3 : 32'h1);
            wr(8'(8'h80 + 4 * i), (i == 1) ? 32'h2 : 32'h0);
            wr(8'(8'hC0 + 4 * i), {16'h0000, pat(i + 1)});
        end
        wr(esq_pkg::REG_TIMEBASE, 32'h4);
        wr(esq_pkg::REG_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk);
        wait_step(5'h01, 1);
        chk("entry pattern", {16'h0, pat(1)}, {16'h0, step_out});
        $display("t_regs done");
    endtask : t_regs

    task automatic t_event_freeze();
        start_req <= 1'b1;
        wait_step(5'h02, 60);
        repeat (60) @(posedge ref_clk);
        wait_step(5'h02, 1);
        chk("pattern", {16'h0, pat(2)}, {16'h0, step_out});
        event_in <= 16'h0002;
        wait_step(5'h03, 40);
        start_req <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rdreg(esq_pkg::REG_STEP_COUNT);
        a = rd;
        rdreg(esq_pkg::REG_TIMER);
        b = rd;
        repeat (30) @(posedge ref_clk);
        rdreg(esq_pkg::REG_STEP_COUNT);
        chk("frozen count", a, rd);
        rdreg(esq_pkg::REG_TIMER);
        chk("frozen timer", b, rd);
        start_req <= 1'b1;
        wait_step(5'h04, 80);
        $display("t_event_freeze done");
    endtask : t_event_freeze

    task automatic t_reset_jog();
        wr(esq_pkg::REG_PRESET, 32'h5);
        rdreg(esq_pkg::REG_PRESET);
        chk("preset", 32'h5, rd);
        reset_req <= 1'b1;
        repeat (50) @(posedge ref_clk);
        wait_step(5'h05, 1);
        rdreg(esq_pkg::REG_STEP_COUNT);
        chk("held count", 32'h0, rd);
        reset_req <= 1'b0;
        start_req <= 1'b0;
        jog();
        jog();
        wait_step(5'h07, 1);
        rdreg(esq_pkg::REG_STEP_COUNT);
        chk("jog count", 32'h0, rd);
        start_req <= 1'b1;
        jog();
        wait_step(5'h09, 40);
        $display("t_reset_jog done");
    endtask : t_reset_jog

    task automatic t_done();
        start_req <= 1'b0;
        for (int k = 0; k < 16 && current_step !== 5'h10; k++) jog();
        jog();
        chk("completion", 32'h1, 32'(completion_flag));
        rdreg(esq_pkg::REG_STEP_COUNT);
        chk("done bit", 32'h1, 32'(rd[16]));
        rdreg(esq_pkg::REG_TIMER);
        chk("timer flag", 32'h0, 32'(rd[16]));
        start_req <= 1'b1;
        jog();
        repeat (20) @(posedge ref_clk);
        wait_step(5'h10, 1);
        chk("completion held", 32'h1, 32'(completion_flag));
        chk("last pattern", 32'h0000FFFF, {16'h0, step_out});
        reset_req <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("completion cleared", 32'h0, 32'(completion_flag));
        wait_step(5'h05, 1);
        reset_req <= 1'b0;
        $display("t_done done");
    endtask : t_done

    task automatic t_auto();
        auto_restart <= 1'b1;
        event_in <= 16'hFFFF;
        for (int n = 0; n < 600 && completion_flag !== 1'b1; n++) @(posedge ref_clk);
        chk("completion", 32'h1, 32'(completion_flag));
        wait_step(5'h05, 20);
        chk("completion cleared", 32'h0, 32'(completion_flag));
        auto_restart <= 1'b0;
        start_req <= 1'b0;
        $display("t_auto done");
    endtask : t_auto

    // watchdog: the whole sequence needs well under 5000 clocks
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_event_freeze();
        t_reset_jog();
        t_done();
        t_auto();
        report_and_stop();
    end
endmodule : esq_event_step_sequencer_tb
